// file: hdl/fcd_pkg.sv
// Package: pin widths, command codes, operations and bus timing of the flash driver
package fcd_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CMD_W  = 8;

  // Unlock addresses, only bits 0..14 carry meaning
  localparam logic [14:0] UNLOCK_ADDR_1 = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR_2 = 15'h2AAA;
  localparam logic [CMD_W-1:0] UNLOCK_DATA_1 = 8'hAA;
  localparam logic [CMD_W-1:0] UNLOCK_DATA_2 = 8'h55;

  // Command codes written in the third (or sixth) cycle
  localparam logic [CMD_W-1:0] CMD_READ_RESET   = 8'hF0;
  localparam logic [CMD_W-1:0] CMD_ID_READ      = 8'h90;
  localparam logic [CMD_W-1:0] CMD_PROGRAM      = 8'hA0;
  localparam logic [CMD_W-1:0] CMD_ERASE_SETUP  = 8'h80;
  localparam logic [CMD_W-1:0] CMD_CHIP_ERASE   = 8'h10;
  localparam logic [CMD_W-1:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [CMD_W-1:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [CMD_W-1:0] CMD_RESUME       = 8'hD0;
  localparam logic [CMD_W-1:0] CMD_STATUS_READ  = 8'h70;
  localparam logic [CMD_W-1:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [CMD_W-1:0] CMD_SLEEP        = 8'hC0;
  localparam logic [CMD_W-1:0] CMD_ABORT        = 8'hE0;

  // Sector field: lowest address bit and width
  localparam int unsigned SECTOR_LSB = 16;
  localparam int unsigned SECTOR_W   = 4;

  // Bus timing in ns and derived cycle counts at the system clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned T_SETUP_NS    = 50;
  localparam int unsigned T_STROBE_W_NS = 100;
  localparam int unsigned T_ACCESS_NS   = 200;
  localparam int unsigned T_HOLD_NS     = 50;
  localparam logic [2:0] SETUP_CYC  = 3'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] WSTRB_CYC  = 3'((T_STROBE_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] ACCESS_CYC = 3'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] HOLD_CYC   = 3'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [3:0] {
    OP_READ, OP_RESET_READ, OP_ID_CMD_READ, OP_ID_HV_READ, OP_PROGRAM,
    OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_SUSPEND, OP_RESUME, OP_STATUS_READ,
    OP_CLEAR_STATUS, OP_SLEEP, OP_ABORT
  } fcd_op_e;

  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_STATUS} fcd_mode_e;
endpackage

// file: hdl/fcd_bus_cycle.sv
// One asynchronous read or write cycle on the flash pins
module fcd_bus_cycle (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_start,
  input  wire logic                        i_write,
  input  wire logic [fcd_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [fcd_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic [fcd_pkg::DATA_W-1:0]  i_dq,
  output logic      [fcd_pkg::ADDR_W-1:0]  o_addr,
  output logic      [fcd_pkg::DATA_W-1:0]  o_dq,
  output logic                             o_dq_oe,
  output logic                             o_ce_n,
  output logic                             o_we_n,
  output logic                             o_oe_n,
  output logic      [fcd_pkg::DATA_W-1:0]  o_rdata,
  output logic                             o_done
);
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fcd_phase_e;
  typedef struct packed {
    fcd_phase_e                 ph;
    logic [2:0]                 cnt;
    logic                       wr;
    logic [fcd_pkg::ADDR_W-1:0] addr;
    logic [fcd_pkg::DATA_W-1:0] wdata;
    logic                       dq_oe;
    logic                       ce_n;
    logic                       we_n;
    logic                       oe_n;
    logic [fcd_pkg::DATA_W-1:0] rdata;
    logic                       done;
  } fcd_cyc_s;

  fcd_cyc_s s_reg;
  fcd_cyc_s s_next;

  // Phase sequencing: address first, then strobe, then release
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.ph)
      PH_IDLE: begin
        if (i_start) begin
          s_next.wr    = i_write;
          s_next.addr  = i_addr;
          s_next.wdata = i_wdata;
          s_next.dq_oe = i_write;
          s_next.ce_n  = 1'b0;
          s_next.cnt   = fcd_pkg::SETUP_CYC - 3'h1;
          s_next.ph    = PH_SETUP;
        end
      end
      PH_SETUP: begin
        if (s_reg.cnt == 3'h0) begin
          // Address stable before write strobe falls  RULE_11
          s_next.we_n = ~s_reg.wr;
          s_next.oe_n = s_reg.wr;
          s_next.cnt  = (s_reg.wr ? fcd_pkg::WSTRB_CYC : fcd_pkg::ACCESS_CYC) - 3'h1;
          s_next.ph   = PH_STROBE;
        end else begin
          s_next.cnt = s_reg.cnt - 3'h1;
        end
      end
      PH_STROBE: begin
        if (s_reg.cnt == 3'h0) begin
          if (!s_reg.wr) begin
            s_next.rdata = i_dq;
          end
          // Data still driven as the write strobe rises  RULE_12
          s_next.we_n = 1'b1;
          s_next.oe_n = 1'b1;
          s_next.cnt  = fcd_pkg::HOLD_CYC - 3'h1;
          s_next.ph   = PH_HOLD;
        end else begin
          s_next.cnt = s_reg.cnt - 3'h1;
        end
      end
      PH_HOLD: begin
        if (s_reg.cnt == 3'h0) begin
          s_next.ce_n  = 1'b1;
          s_next.dq_oe = 1'b0;
          s_next.done  = 1'b1;
          s_next.ph    = PH_IDLE;
        end else begin
          s_next.cnt = s_reg.cnt - 3'h1;
        end
      end
      default: begin
        s_next.ph = PH_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s_reg       <= '0;
      s_reg.ph    <= PH_IDLE;
      s_reg.ce_n  <= 1'b1;
      s_reg.we_n  <= 1'b1;
      s_reg.oe_n  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Pins straight from the state register
  assign o_addr  = s_reg.addr;
  assign o_dq    = s_reg.wdata;
  assign o_dq_oe = s_reg.dq_oe;
  assign o_ce_n  = s_reg.ce_n;
  assign o_we_n  = s_reg.we_n;
  assign o_oe_n  = s_reg.oe_n;
  assign o_rdata = s_reg.rdata;
  assign o_done  = s_reg.done;
endmodule

// file: hdl/fcd_flash_host.sv
// Host controller that drives the flash command decoder through its pins
// Notes on behaviour
// RULE_01 - High voltage on address bit 9 makes reads return identifier words.
// RULE_02 - In high-voltage identifier mode only address bits 0 and 1 matter.
// RULE_03 - Bit 1 low: bit 0 low gives maker code, high gives part code.
// RULE_04 - Unlock then 90H; reads at 00H and 01H give identifier words.
// RULE_05 - Identifier mode ends only by the full read/reset sequence; here 70H, program, sector or chip erase and B0H end it too.
// RULE_06 - Unlock then F0H returns reads to array data.
// RULE_07 - Array mode holds until another valid command sequence is accepted.
// RULE_08 - Power-up state is array read; no program or erase starts spuriously.
// RULE_09 - Unlock is AAH to 5555H then 55H to 2AAAH, bits 0..14 compared.
// RULE_10 - Address bits 15..19 are don't care except program and sector addresses.
// RULE_11 - Program: unlock, A0H, then data to target; address latched at strobe fall.
// RULE_12 - Program data captured at the rising write strobe.
// RULE_13 - Sector erase: unlock, 80H, unlock, 30H at an address inside the sector.
// RULE_14 - Sector chosen only by address bits 16..19 of the last write.
// RULE_15 - Unlock then 70H; the next read returns status whatever the address.
// RULE_16 - Chip erase: unlock, 80H, unlock, 10H at the first unlock address.
// RULE_17 - Three-cycle commands: B0H, D0H, 50H, C0H, E0H.
// RULE_18 - A broken pattern is discarded and the read mode is kept.
module fcd_flash_host (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_cmd_valid,
  input  wire fcd_pkg::fcd_op_e            i_cmd_op,
  input  wire logic [fcd_pkg::ADDR_W-1:0]  i_cmd_addr,
  input  wire logic [fcd_pkg::DATA_W-1:0]  i_cmd_data,
  output logic                             o_cmd_ready,
  output logic                             o_rsp_valid,
  output logic      [fcd_pkg::DATA_W-1:0]  o_rsp_data,
  output fcd_pkg::fcd_mode_e               o_read_mode,
  output logic      [fcd_pkg::ADDR_W-1:0]  o_addr,
  input  wire logic [fcd_pkg::DATA_W-1:0]  i_dq,
  output logic      [fcd_pkg::DATA_W-1:0]  o_dq,
  output logic                             o_dq_oe,
  output logic                             o_ce_n,
  output logic                             o_we_n,
  output logic                             o_oe_n,
  output logic                             o_identifier_high_voltage
);
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fcd_state_e;
  typedef struct packed {
    fcd_state_e                 st;
    fcd_pkg::fcd_op_e           op;
    logic [2:0]                 step;
    logic [fcd_pkg::ADDR_W-1:0] addr;
    logic [fcd_pkg::DATA_W-1:0] data;
    logic                       start;
    logic                       ready;
    logic                       hv;
    fcd_pkg::fcd_mode_e         mode;
    logic                       rsp_valid;
    logic [fcd_pkg::DATA_W-1:0] rsp_data;
  } fcd_host_s;

  fcd_host_s s_reg;
  fcd_host_s s_next;

  logic                       cyc_write;
  logic [fcd_pkg::ADDR_W-1:0] cyc_addr;
  logic [fcd_pkg::DATA_W-1:0] cyc_data;
  logic [2:0]                 last_step;
  logic [fcd_pkg::DATA_W-1:0] eng_rdata;
  logic                       eng_done;

  // Unlock write with bits 15..19 left at zero
  function automatic logic [fcd_pkg::ADDR_W-1:0] unlock_addr(input logic [14:0] a);
    unlock_addr = {5'h00, a}; // RULE_10
  endfunction

  // Bus cycle for the current step of the current operation
  always_comb begin
    cyc_write = 1'b1;
    cyc_addr  = unlock_addr(fcd_pkg::UNLOCK_ADDR_1);
    cyc_data  = {8'h00, fcd_pkg::UNLOCK_DATA_1};
    last_step = 3'h2;
    case (s_reg.op)
      fcd_pkg::OP_READ: begin
        last_step = 3'h0;
      end
      fcd_pkg::OP_ID_HV_READ: begin
        last_step = 3'h0;
      end
      fcd_pkg::OP_RESET_READ, fcd_pkg::OP_ID_CMD_READ, fcd_pkg::OP_STATUS_READ,
      fcd_pkg::OP_PROGRAM: begin
        last_step = 3'h3;
      end
      fcd_pkg::OP_CHIP_ERASE, fcd_pkg::OP_SECTOR_ERASE: begin
        last_step = 3'h5;
      end
      default: begin
        last_step = 3'h2;
      end
    endcase
    if (s_reg.op == fcd_pkg::OP_READ) begin
      cyc_write = 1'b0;
      cyc_addr  = s_reg.addr;
    end else if (s_reg.op == fcd_pkg::OP_ID_HV_READ) begin
      // Only bits 0 and 1 select the identifier word  RULE_02 RULE_03
      cyc_write = 1'b0;
      cyc_addr  = {18'h0, s_reg.addr[1:0]};
    end else begin
      // Four-cycle sequences end at step 3, so it takes the final branch
      case ((last_step == 3'h3 && s_reg.step == 3'h3) ? 3'h5 : s_reg.step)
        3'h0, 3'h3: begin
          cyc_addr = unlock_addr(fcd_pkg::UNLOCK_ADDR_1); // RULE_09
          cyc_data = {8'h00, fcd_pkg::UNLOCK_DATA_1};
        end
        3'h1, 3'h4: begin
          cyc_addr = unlock_addr(fcd_pkg::UNLOCK_ADDR_2); // RULE_09
          cyc_data = {8'h00, fcd_pkg::UNLOCK_DATA_2};
        end
        3'h2: begin
          case (s_reg.op)
            fcd_pkg::OP_RESET_READ:   cyc_data = {8'h00, fcd_pkg::CMD_READ_RESET}; // RULE_06
            fcd_pkg::OP_ID_CMD_READ:  cyc_data = {8'h00, fcd_pkg::CMD_ID_READ}; // RULE_04
            fcd_pkg::OP_PROGRAM:      cyc_data = {8'h00, fcd_pkg::CMD_PROGRAM}; // RULE_11
            fcd_pkg::OP_CHIP_ERASE:   cyc_data = {8'h00, fcd_pkg::CMD_ERASE_SETUP}; // RULE_16
            fcd_pkg::OP_SECTOR_ERASE: cyc_data = {8'h00, fcd_pkg::CMD_ERASE_SETUP}; // RULE_13
            fcd_pkg::OP_STATUS_READ:  cyc_data = {8'h00, fcd_pkg::CMD_STATUS_READ}; // RULE_15
            fcd_pkg::OP_SUSPEND:      cyc_data = {8'h00, fcd_pkg::CMD_SUSPEND}; // RULE_17
            fcd_pkg::OP_RESUME:       cyc_data = {8'h00, fcd_pkg::CMD_RESUME}; // RULE_17
            fcd_pkg::OP_CLEAR_STATUS: cyc_data = {8'h00, fcd_pkg::CMD_CLEAR_STATUS}; // RULE_17
            fcd_pkg::OP_SLEEP:        cyc_data = {8'h00, fcd_pkg::CMD_SLEEP}; // RULE_17
            default:                  cyc_data = {8'h00, fcd_pkg::CMD_ABORT}; // RULE_17
          endcase
        end
        default: begin
          if (s_reg.op == fcd_pkg::OP_CHIP_ERASE) begin
            cyc_data = {8'h00, fcd_pkg::CMD_CHIP_ERASE}; // RULE_16
          end else if (s_reg.op == fcd_pkg::OP_SECTOR_ERASE) begin
            cyc_addr = {s_reg.addr[fcd_pkg::SECTOR_LSB +: fcd_pkg::SECTOR_W],
                        16'h0000}; // RULE_14
            cyc_data = {8'h00, fcd_pkg::CMD_SECTOR_ERASE}; // RULE_13
          end else if (s_reg.op == fcd_pkg::OP_PROGRAM) begin
            cyc_addr = s_reg.addr; // RULE_11
            cyc_data = s_reg.data; // RULE_12
          end else begin
            // Fourth cycle of a read command is a read  RULE_04 RULE_06 RULE_15
            cyc_write = 1'b0;
            cyc_addr  = (s_reg.op == fcd_pkg::OP_ID_CMD_READ) ?
                        {19'h0, s_reg.addr[0]} : s_reg.addr;
          end
        end
      endcase
    end
  end

  // Sequencer: whole sequences only, never abandoned midway
  always_comb begin
    s_next           = s_reg;
    s_next.start     = 1'b0;
    s_next.rsp_valid = 1'b0;
    case (s_reg.st)
      ST_IDLE: begin
        if (i_cmd_valid) begin
          s_next.op    = i_cmd_op;
          s_next.addr  = i_cmd_addr;
          s_next.data  = i_cmd_data;
          s_next.step  = 3'h0;
          s_next.ready = 1'b0;
          s_next.hv    = (i_cmd_op == fcd_pkg::OP_ID_HV_READ); // RULE_01
          s_next.st    = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        s_next.start = 1'b1;
        s_next.st    = ST_WAIT;
      end
      ST_WAIT: begin
        if (eng_done) begin
          if (!cyc_write) begin
            s_next.rsp_data = eng_rdata;
          end
          if (s_reg.step == last_step) begin
            s_next.rsp_valid = 1'b1;
            s_next.ready     = 1'b1;
            s_next.hv        = 1'b0;
            s_next.st        = ST_IDLE;
            // Track the device read path after a complete sequence  RULE_18
            case (s_reg.op)
              fcd_pkg::OP_RESET_READ:  s_next.mode = fcd_pkg::MODE_ARRAY; // RULE_05 RULE_07
              fcd_pkg::OP_ID_CMD_READ: s_next.mode = fcd_pkg::MODE_ID;
              fcd_pkg::OP_STATUS_READ, fcd_pkg::OP_PROGRAM, fcd_pkg::OP_CHIP_ERASE,
              fcd_pkg::OP_SECTOR_ERASE, fcd_pkg::OP_SUSPEND:
                s_next.mode = fcd_pkg::MODE_STATUS;
              default: s_next.mode = s_reg.mode;
            endcase
          end else begin
            s_next.step = s_reg.step + 3'h1;
            s_next.st   = ST_ISSUE;
          end
        end
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  // State register; reset assumes the device's power-up array mode
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s_reg       <= '0;
      s_reg.st    <= ST_IDLE;
      s_reg.ready <= 1'b1;
      s_reg.mode  <= fcd_pkg::MODE_ARRAY; // RULE_08
    end else begin
      s_reg <= s_next;
    end
  end

  // Pin timing engine
  fcd_bus_cycle fcd_bus_cycle_inst (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_start   (s_reg.start),
    .i_write   (cyc_write),
    .i_addr    (cyc_addr),
    .i_wdata   (cyc_data),
    .i_dq      (i_dq),
    .o_addr    (o_addr),
    .o_dq      (o_dq),
    .o_dq_oe   (o_dq_oe),
    .o_ce_n    (o_ce_n),
    .o_we_n    (o_we_n),
    .o_oe_n    (o_oe_n),
    .o_rdata   (eng_rdata),
    .o_done    (eng_done)
  );

  // User-side outputs from the state register
  assign o_cmd_ready               = s_reg.ready;
  assign o_rsp_valid               = s_reg.rsp_valid;
  assign o_rsp_data                = s_reg.rsp_data;
  assign o_read_mode               = s_reg.mode;
  assign o_identifier_high_voltage = s_reg.hv;
endmodule

// file: testbench/fcd_flash_dev.sv
// Behavioural flash device: command decoder, array, identifier and status read paths
module fcd_flash_dev #(
  parameter logic [7:0]  MAKER_CODE  = 8'h3C, // Arbitrary value
  parameter logic [7:0]  PART_CODE   = 8'h5D, // Arbitrary value
  parameter logic [15:0] STATUS_WORD = 16'h0080
) (
  input  wire logic [19:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_hv,
  output logic      [15:0] o_dq
);
  timeunit 1ns;
  timeprecision 1ns;
  fcd_pkg::fcd_mode_e mode = fcd_pkg::MODE_ARRAY;
  int          step = 0;
  int          erases = 0;
  int          chips = 0;
  logic [7:0]  last_cmd = 8'h00;
  logic [3:0]  sector = 4'h0;
  logic [19:0] wa = 20'h00000;
  logic [15:0] rd;
  logic [15:0] idw;
  logic [15:0] last = 16'h0000;
  logic [15:0] mem [logic [19:0]];
  // Address taken as the write strobe falls
  always @(negedge i_we_n) if (i_ce_n === 1'b0) wa = i_addr;
  // Sequence decoder steps as the write strobe rises, data taken here
  always @(posedge i_we_n) begin
    if (i_ce_n === 1'b0) begin
      case (step)
        0, 3: step = (wa[14:0] == 15'h5555 && i_dq == 16'h00AA) ? step + 1 : 0;
        1, 4: step = (wa[14:0] == 15'h2AAA && i_dq == 16'h0055) ? step + 1 : 0;
        2: begin
          step = 0;
          if (wa[14:0] == 15'h5555) begin
            case (i_dq)
              16'h00F0: mode = fcd_pkg::MODE_ARRAY;
              16'h0090: mode = fcd_pkg::MODE_ID;
              16'h0070: mode = fcd_pkg::MODE_STATUS;
              16'h00A0: step = 6;
              16'h0080: step = 3;
              16'h00B0, 16'h00D0, 16'h0050, 16'h00C0, 16'h00E0: begin
                last_cmd = i_dq[7:0];
                if (i_dq == 16'h00B0) mode = fcd_pkg::MODE_STATUS;
              end
              default: ;
            endcase
          end
        end
        5: begin
          step = 0;
          if (i_dq == 16'h0030) begin
            sector = wa[19:16];
            erases++;
            mode = fcd_pkg::MODE_STATUS;
          end else if (i_dq == 16'h0010 && wa[14:0] == 15'h5555) begin
            chips++;
            mode = fcd_pkg::MODE_STATUS;
          end
        end
        default: begin
          mem[wa] = i_dq;
          mode = fcd_pkg::MODE_STATUS;
          step = 0;
        end
      endcase
    end
  end
  // Read path: high voltage identifier wins over the decoded mode
  always @(i_addr, i_hv, mode, i_oe_n) begin
    idw = {8'h00, i_addr[0] ? PART_CODE : MAKER_CODE};
    if (i_hv) rd = i_addr[1] ? 16'h0000 : idw;
    else if (mode == fcd_pkg::MODE_ID) rd = idw;
    else if (mode == fcd_pkg::MODE_STATUS) rd = STATUS_WORD;
    else rd = mem.exists(i_addr) ? mem[i_addr] : i_addr[15:0] ^ 16'h5A5A;
  end
  // Released bus shows the inverse of the last word, never a stale copy
  assign o_dq = (i_ce_n === 1'b0 && i_oe_n === 1'b0) ? rd : ~last;
  always @(posedge i_oe_n) last = rd;
endmodule

// file: testbench/fcd_flash_host_chk.sv
// Checker: strobe and handshake relations on the flash host ports
module fcd_flash_host_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic        i_cmd_valid,
  input wire logic        o_cmd_ready,
  input wire logic        o_rsp_valid,
  input wire logic [19:0] o_addr,
  input wire logic [15:0] o_dq,
  input wire logic        o_dq_oe,
  input wire logic        o_ce_n,
  input wire logic        o_we_n,
  input wire logic        o_oe_n,
  input wire logic        o_identifier_high_voltage
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Pin relations
  a_we_in_ce:
    assert property (!o_we_n |-> !o_ce_n) else $error("write strobe outside select");
  a_no_we_oe:
    assert property (o_we_n || o_oe_n) else $error("both strobes low");
  a_we_drives:
    assert property (!o_we_n |-> o_dq_oe) else $error("write without bus drive");
  a_we_rise_hold:
    assert property ($rose(o_we_n) |-> $stable(o_dq) && $stable(o_addr))
      else $error("data or address moved at strobe rise");
  a_read_free:
    assert property (!o_oe_n |-> !o_dq_oe) else $error("bus driven during read");
  a_hv_addr:
    assert property (o_identifier_high_voltage && !o_oe_n |-> o_addr[19:2] == 18'h0)
      else $error("high address bits set in identifier read");
  a_hv_no_write:
    assert property (o_identifier_high_voltage |-> o_we_n) else $error("write under high voltage");
  // Handshake
  a_busy_answer:
    assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready ##[3:80] o_rsp_valid)
      else $error("request not answered in time");
  a_rsp_pulse:
    assert property (o_rsp_valid |-> o_cmd_ready ##1 !o_rsp_valid) else $error("bad response pulse");
  c_sector: cover property (!o_we_n && o_dq == 16'h0030);
  c_hv_read: cover property (o_identifier_high_voltage && !o_oe_n);
  c_back: cover property (o_rsp_valid && i_cmd_valid);
endmodule

// file: testbench/fcd_flash_host_tb.sv
// Testbench: flash host against a behavioural flash device
module fcd_flash_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0]  PART  = 8'h5D; // Arbitrary value
  localparam logic [15:0] STAT  = 16'h0080;
  logic               i_clk_sys = 1'b0;
  logic               i_rst_n = 1'b0;
  logic               i_cmd_valid = 1'b0;
  fcd_pkg::fcd_op_e   i_cmd_op = fcd_pkg::OP_READ;
  logic [19:0]        i_cmd_addr = 20'h00000;
  logic [15:0]        i_cmd_data = 16'h0000;
  logic               o_cmd_ready, o_rsp_valid, o_dq_oe, o_ce_n, o_we_n, o_oe_n;
  logic               o_identifier_high_voltage;
  logic [15:0]        o_rsp_data, o_dq, i_dq, dev_dq, r;
  logic [19:0]        o_addr;
  fcd_pkg::fcd_mode_e o_read_mode;
  int                 fail_count = 0;
  int                 checks = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  // Shared data bus
  assign i_dq = o_dq_oe ? o_dq : dev_dq;
  fcd_flash_host fcd_flash_host_inst (.i_clk_sys, .i_rst_n, .i_cmd_valid, .i_cmd_op,
    .i_cmd_addr, .i_cmd_data, .o_cmd_ready, .o_rsp_valid, .o_rsp_data, .o_read_mode, .o_addr,
    .i_dq, .o_dq, .o_dq_oe, .o_ce_n, .o_we_n, .o_oe_n, .o_identifier_high_voltage);
  fcd_flash_dev #(.MAKER_CODE(MAKER), .PART_CODE(PART), .STATUS_WORD(STAT)) fcd_flash_dev_inst (
    .i_addr(o_addr), .i_dq(i_dq), .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
    .i_hv(o_identifier_high_voltage), .o_dq(dev_dq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkm(input fcd_pkg::fcd_mode_e e);
    chk(16'(o_read_mode), 16'(e));
  endtask
  task automatic wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One request, entered and left at a falling edge
  task automatic op(input fcd_pkg::fcd_op_e o, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 200) begin
      @(negedge i_clk_sys);
      n++;
    end
    i_cmd_valid = 1'b1;
    i_cmd_op = o;
    i_cmd_addr = a;
    i_cmd_data = d;
    @(negedge i_clk_sys);
    i_cmd_valid = 1'b0;
    while (o_rsp_valid !== 1'b1 && n < 200) begin
      @(negedge i_clk_sys);
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      $display("[ERR] t=%0t wait ran out n=%h limit=%h", $time, n, 200);
      wrap_up();
    end
    r = o_rsp_data;
  endtask
  task automatic t_power_up;
    op(fcd_pkg::OP_READ, 20'h12345, 16'h0000);
    chk(r, 16'h2345 ^ 16'h5A5A);
    chkm(fcd_pkg::MODE_ARRAY);
    chk(16'(fcd_flash_dev_inst.erases + fcd_flash_dev_inst.chips), 16'h0000);
    $display("power-up test done");
  endtask
  task automatic t_program;
    op(fcd_pkg::OP_PROGRAM, 20'hF8765, 16'hC3A5);
    chkm(fcd_pkg::MODE_STATUS);
    op(fcd_pkg::OP_READ, 20'h00000, 16'h0000);
    chk(r, STAT);
    op(fcd_pkg::OP_STATUS_READ, 20'hFFFFF, 16'h0000);
    chk(r, STAT);
    op(fcd_pkg::OP_RESET_READ, 20'hF8765, 16'h0000);
    chk(r, 16'hC3A5);
    op(fcd_pkg::OP_READ, 20'h78765, 16'h0000);
    chk(r, 16'h8765 ^ 16'h5A5A);
    $display("program test done");
  endtask
  task automatic t_ident;
    op(fcd_pkg::OP_ID_CMD_READ, 20'h00000, 16'h0000);
    chk(r, {8'h00, MAKER});
    op(fcd_pkg::OP_READ, 20'h00001, 16'h0000);
    chk(r, {8'h00, PART});
    chkm(fcd_pkg::MODE_ID);
    op(fcd_pkg::OP_RESET_READ, 20'h00001, 16'h0000);
    chk(r, 16'h0001 ^ 16'h5A5A);
    op(fcd_pkg::OP_ID_HV_READ, 20'hFFFFC, 16'h0000);
    chk(r, {8'h00, MAKER});
    op(fcd_pkg::OP_ID_HV_READ, 20'hABCD1, 16'h0000);
    chk(r, {8'h00, PART});
    chkm(fcd_pkg::MODE_ARRAY);
    $display("identifier test done");
  endtask
  task automatic t_erase;
    fcd_pkg::fcd_op_e ops[5];
    logic [7:0] codes[5];
    ops = '{fcd_pkg::OP_SUSPEND, fcd_pkg::OP_RESUME, fcd_pkg::OP_CLEAR_STATUS,
            fcd_pkg::OP_SLEEP, fcd_pkg::OP_ABORT};
    codes = '{8'hB0, 8'hD0, 8'h50, 8'hC0, 8'hE0};
    op(fcd_pkg::OP_SECTOR_ERASE, 20'hA1234, 16'h0000);
    chk(16'(fcd_flash_dev_inst.sector), 16'h000A);
    chk(16'(fcd_flash_dev_inst.erases), 16'h0001);
    op(fcd_pkg::OP_CHIP_ERASE, 20'h00000, 16'h0000);
    chk(16'(fcd_flash_dev_inst.chips), 16'h0001);
    chkm(fcd_pkg::MODE_STATUS);
    for (int i = 0; i < 5; i++) begin
      op(ops[i], 20'h00000, 16'h0000);
      chk(16'(fcd_flash_dev_inst.last_cmd), 16'(codes[i]));
    end
    $display("erase and short command test done");
  endtask
  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    t_power_up();
    t_program();
    t_ident();
    t_erase();
    wrap_up();
  end
endmodule
bind fcd_flash_host fcd_flash_host_chk fcd_flash_host_chk_inst (.i_clk_sys, .i_rst_n,
  .i_cmd_valid, .o_cmd_ready, .o_rsp_valid, .o_addr, .o_dq, .o_dq_oe, .o_ce_n, .o_we_n,
  .o_oe_n, .o_identifier_high_voltage);
